// ### shared/swmwc_pkg.sv
`default_nettype none
package swmwc_pkg;
  // ==========================================================
  // clock and pointer/command codes
  localparam int CLK_NS = 10;
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_RDATA = 8'he1;
  localparam logic [7:0] PTR_CONFIG = 8'hc3;
  localparam logic [7:0] CMD_DEV_RESET = 8'hf0;
  localparam logic [7:0] CMD_SET_PTR = 8'he1;
  localparam logic [7:0] CMD_WRITE_CFG = 8'h3c;
  localparam logic [7:0] CMD_BUS_RESET = 8'h4b;
  localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h5a;
  localparam logic [7:0] CMD_READ_BYTE = 8'h96;
  localparam logic [7:0] CMD_TRIPLET = 8'h69;
  localparam int PARAM_BIT = 7;
  localparam logic [4:0] I2C_ADDR_BASE = 5'h0c;
  // ==========================================================
  // register layout
  localparam int CFG_APU = 0;
  localparam int CFG_PPM = 1;
  localparam int CFG_SPU = 2;
  localparam int CFG_ODS = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int ST_BUSY = 0;
  localparam int ST_PRES = 1;
  localparam int ST_SHORT = 2;
  localparam int ST_LEVEL = 3;
  localparam int ST_RST = 4;
  localparam int ST_SBR = 5;
  localparam int ST_TSB = 6;
  localparam int ST_DIR = 7;
  localparam logic [7:0] STATUS_RESET = 8'h10;
  // ==========================================================
  // waveform times in ns, cycles rounded up
  function automatic int cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  localparam int T_SLOT_STD_NS = 65000;
  localparam int T_LOW0_STD_NS = 60000;
  localparam int T_LOW1_STD_NS = 6000;
  localparam int T_MSR_STD_NS = 15000;
  localparam int T_RSTL_STD_NS = 480000;
  localparam int T_RSTH_STD_NS = 480000;
  localparam int T_MSP_STD_NS = 70000;
  localparam int T_SSI_STD_NS = 10000;
  localparam int T_MASK1_NS = 2000;
  localparam int T_MASK2_NS = 8000;
  localparam int T_SLOT_OD_NS = 10000;
  localparam int T_LOW0_OD_NS = 7500;
  localparam int T_LOW1_OD_NS = 1000;
  localparam int T_MSR_OD_NS = 2000;
  localparam int T_RSTL_OD_NS = 48000;
  localparam int T_RSTH_OD_NS = 48000;
  localparam int T_MSP_OD_NS = 8000;
  localparam int T_SSI_OD_NS = 2000;
  localparam int T_APUOT_NS = 2500;
  localparam int SLOT_STD_CYC = cyc(T_SLOT_STD_NS);
  localparam int LOW0_STD_CYC = cyc(T_LOW0_STD_NS);
  localparam int LOW1_STD_CYC = cyc(T_LOW1_STD_NS);
  localparam int MSR_STD_CYC = cyc(T_MSR_STD_NS);
  localparam int RSTL_STD_CYC = cyc(T_RSTL_STD_NS);
  localparam int RSTH_STD_CYC = cyc(T_RSTH_STD_NS);
  localparam int MSP_STD_CYC = cyc(T_MSP_STD_NS);
  localparam int SSI_STD_CYC = cyc(T_SSI_STD_NS);
  localparam int MASK1_CYC = cyc(T_MASK1_NS);
  localparam int MASK2_CYC = cyc(T_MASK2_NS);
  localparam int SLOT_OD_CYC = cyc(T_SLOT_OD_NS);
  localparam int LOW0_OD_CYC = cyc(T_LOW0_OD_NS);
  localparam int LOW1_OD_CYC = cyc(T_LOW1_OD_NS);
  localparam int MSR_OD_CYC = cyc(T_MSR_OD_NS);
  localparam int RSTL_OD_CYC = cyc(T_RSTL_OD_NS);
  localparam int RSTH_OD_CYC = cyc(T_RSTH_OD_NS);
  localparam int MSP_OD_CYC = cyc(T_MSP_OD_NS);
  localparam int SSI_OD_CYC = cyc(T_SSI_OD_NS);
  localparam int APUOT_CYC = cyc(T_APUOT_NS);
  // ==========================================================
  // carriers
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RESET = 2'b01,
    SEQ_BITS = 2'b10,
    SEQ_TRIP = 2'b11
  } swmwc_seq_e;
  typedef struct packed {
    logic start;
    logic rst_slot;
    logic wbit;
    logic hold;
    logic od;
    logic active_pullup_en;
    logic mask;
  } swmwc_slot_req_s;
  typedef struct packed {
    logic done;
    logic sample;
    logic pres;
    logic short_det;
    logic pull_lo;
    logic pull_hi;
    logic rise;
  } swmwc_slot_rsp_s;
  typedef struct packed {
    logic busy;
    logic rst;
    logic wbit;
    logic hold;
    logic od;
    logic active_pullup_en;
    logic mask;
    logic apu_done;
    logic apu_on;
    logic [16:0] cnt;
    logic [16:0] apu_cnt;
    swmwc_slot_rsp_s rsp;
  } swmwc_slot_st_s;
endpackage
`default_nettype wire

// ### test/swmwc_slave.sv
`default_nettype none
module swmwc_slave #(
  parameter int RST_MIN = 1500,
  parameter int P_WAIT = 3000,
  parameter int P_LEN = 4500,
  parameter int B_LEN = 1800
) (
  input wire logic core_clk,
  input wire logic line,
  input wire logic present,
  input wire logic reply_zero,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_n;
  // ==========
  // only low pulses reach the line; release goes to the pull-up level
  initial begin
    pull = 1'b0;
    forever begin
      @(negedge line);
      low_n = 0;
      if (reply_zero) begin
        pull <= 1'b1;
        repeat (B_LEN) @(posedge core_clk);
        pull <= 1'b0;
      end else begin
        while (line === 1'b0) begin
          @(posedge core_clk);
          low_n++;
        end
        // deaf while presenting, so the mask pulse is not taken as a reset
        if (present && low_n >= RST_MIN) begin
          repeat (P_WAIT) @(posedge core_clk);
          pull <= 1'b1;
          repeat (P_LEN) @(posedge core_clk);
          pull <= 1'b0;
        end
      end
    end
  end
endmodule // swmwc_slave
`default_nettype wire

// ### test/swmwc_top_monitor.sv
`default_nettype none
module swmwc_top_monitor
  import swmwc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param,
  input wire logic cmd_ack,
  input wire logic cmd_nack,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic ext_pullup_ctrl_n,
  input wire logic addr_sel_lo,
  input wire logic addr_sel_hi,
  input wire logic [6:0] i2c_addr
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  int hi_run;
  logic cfg_bad;
  assign cfg_bad = cmd_valid && cmd_code == CMD_WRITE_CFG
    && cmd_param[7:4] != ~cmd_param[3:0];
  // ==========
  // drive-high run; strong pullup excluded since it may last long
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hi_run <= 0;
    end else if (line_oe && line_out && ext_pullup_ctrl_n) begin
      hi_run <= hi_run + 1;
    end else begin
      hi_run <= 0;
    end
  end
  sequence s_bus_reset_taken;
    cmd_valid && cmd_code == CMD_BUS_RESET ##1 cmd_ack;
  endsequence
  sequence s_devrst_taken;
    cmd_valid && cmd_code == CMD_DEV_RESET ##1 cmd_ack;
  endsequence
  a_cmd_answered: assert property (cmd_valid |=> cmd_ack ^ cmd_nack)
    else $error("command not answered once");
  a_no_stray: assert property (!cmd_valid |=> !(cmd_ack || cmd_nack))
    else $error("answer without command");
  a_read_answer: assert property (rd_valid == $past(rd_req))
    else $error("read answer mistimed");
  a_cfg_refused: assert property (cfg_bad |=> cmd_nack)
    else $error("bad config byte accepted");
  a_devrst_clears: assert property (s_devrst_taken |-> ##2 ext_pullup_ctrl_n [*3])
    else $error("strong pullup survives device reset");
  a_addr_follows: assert property (1 |=> i2c_addr == {I2C_ADDR_BASE, $past(addr_sel_hi),
    $past(addr_sel_lo)})
    else $error("address does not follow straps");
  a_reset_pulls_low: assert property (s_bus_reset_taken |-> ##2 line_oe && !line_out)
    else $error("bus reset does not pull low");
  a_strong_drive: assert property (!ext_pullup_ctrl_n |-> line_oe && line_out)
    else $error("external control without strong drive");
  a_apu_on_time: assert property (hi_run <= APUOT_CYC)
    else $error("active pullup too long");
endmodule // swmwc_top_monitor
bind swmwc_top swmwc_top_monitor u_monitor (.core_clk, .reset, .cmd_valid, .cmd_code,
  .cmd_param, .cmd_ack, .cmd_nack, .rd_req, .rd_valid, .line_out, .line_oe,
  .ext_pullup_ctrl_n, .addr_sel_lo, .addr_sel_hi, .i2c_addr);
`default_nettype wire

// ### test/swmwc_top_test.sv
`default_nettype none
module swmwc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import swmwc_pkg::*;
  localparam int RSTL = 2000;
  localparam int RSTH = 8000;
  logic core_clk = 0, reset = 1, cmd_valid = 0, rd_req = 0, present = 1, reply_zero = 0;
  logic addr_sel_lo = 0, addr_sel_hi = 0, spu_on = 0;
  logic [7:0] cmd_code = 8'h00, cmd_param = 8'h00, rd_data, cfg_m, st_m, ptr_m, d;
  logic cmd_ack, cmd_nack, rd_valid, line_out, line_oe, ext_pullup_ctrl_n, pull, line;
  logic [6:0] i2c_addr;
  logic [3:0] lo;
  int n_errors = 0, total_checks = 0, cyc, lo_n = 0;
  always #5 core_clk = ~core_clk;
  // cycles this end drives the line low during the current bus command
  always @(negedge core_clk) begin
    if (line_oe === 1'b1 && line_out === 1'b0) begin
      lo_n++;
    end
  end
  // wired-and line with pull-up
  assign line = (line_oe ? line_out : 1'b1) & ~pull;
  swmwc_top #(.RSTL_STD(RSTL), .RSTH_STD(RSTH)) uut (.core_clk, .reset, .cmd_valid,
    .cmd_code, .cmd_param, .cmd_ack, .cmd_nack, .rd_req, .rd_valid, .rd_data,
    .line_in(line), .line_out, .line_oe, .ext_pullup_ctrl_n, .addr_sel_lo, .addr_sel_hi,
    .i2c_addr);
  swmwc_slave u_slave (.core_clk, .line, .present, .reply_zero, .pull);
  // ==========
  // checking and bus tasks
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] prm, input logic ok);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_param = prm;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    chk("cmd_ack", {7'h00, ok}, {7'h00, cmd_ack});
    chk("cmd_nack", {7'h00, ~ok}, {7'h00, cmd_nack});
    if (ok && code == CMD_SET_PTR) begin
      ptr_m = prm;
    end else if (ok && code == CMD_WRITE_CFG) begin
      cfg_m = {4'h0, prm[3:0]};
      st_m[ST_RST] = 1'b0;
      ptr_m = PTR_CONFIG;
      spu_on = 1'b0;
    end else if (ok && code == CMD_DEV_RESET) begin
      cfg_m = 8'h00;
      st_m = STATUS_RESET;
      ptr_m = PTR_STATUS;
      spu_on = 1'b0;
    end else if (ok) begin
      ptr_m = PTR_STATUS;
      if (spu_on) cfg_m[CFG_SPU] = 1'b0;
      spu_on = cfg_m[CFG_SPU] && code == CMD_SINGLE_BIT;
    end
  endtask
  task automatic rd(input logic cmp);
    logic lvl;
    @(negedge core_clk);
    rd_req = 1'b1;
    lvl = line;
    @(negedge core_clk);
    rd_req = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    d = rd_data;
    if (cmp) chk("rd_data", ptr_m == PTR_CONFIG ? cfg_m : {st_m[7:4], lvl, st_m[2:0]}, d);
  endtask
  // a bus command, refused once while busy, then polled to completion
  task automatic bus(input logic [7:0] code, input int len);
    lo_n = 0;
    cmd(code, 8'h80, 1'b1);
    cmd(CMD_BUS_RESET, 8'h00, 1'b0);
    cyc = 4;
    rd(1'b0);
    while (d[ST_BUSY] !== 1'b0 && cyc < 24000) begin
      rd(1'b0);
      cyc += 2;
    end
    chk("busy_len", 8'h01, {7'h00, cyc >= len - 60 && cyc <= len + 60});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
  // ==========
  // scenarios
  initial begin
    void'($urandom(32'hf39bf634));
    cfg_m = 8'h00;
    st_m = STATUS_RESET;
    ptr_m = PTR_STATUS;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    rd(1'b1);
    cmd(CMD_SET_PTR, PTR_CONFIG, 1'b1);
    rd(1'b1);
    cmd(CMD_SET_PTR, 8'h5a, 1'b0);
    rd(1'b1);
    repeat (6) begin
      lo = 4'($urandom);
      cmd(CMD_WRITE_CFG, {~lo, lo}, 1'b1);
      rd(1'b1);
      cmd(CMD_WRITE_CFG, {~lo ^ (4'($urandom) | 4'h1), lo}, 1'b0);
      rd(1'b1);
    end
    cmd(CMD_SET_PTR, PTR_STATUS, 1'b1);
    rd(1'b1);
    for (int i = 0; i < 4; i++) begin
      {addr_sel_hi, addr_sel_lo} = 2'(i);
      @(negedge core_clk);
      chk("i2c_addr", {1'b0, I2C_ADDR_BASE, 2'(i)}, {1'b0, i2c_addr});
    end
    cmd(CMD_WRITE_CFG, 8'he1, 1'b1);
    for (int z = 0; z < 2; z++) begin
      reply_zero = z[0];
      bus(CMD_SINGLE_BIT, SLOT_STD_CYC);
      st_m[ST_SBR] = ~z[0];
      rd(1'b1);
    end
    reply_zero = 1'b0;
    cmd(CMD_WRITE_CFG, 8'h78, 1'b1);
    bus(CMD_SINGLE_BIT, SLOT_OD_CYC);
    // a released one-bit reads back high at the sample point
    st_m[ST_SBR] = 1'b1;
    cmd(CMD_WRITE_CFG, 8'hd2, 1'b1);
    for (int p = 1; p >= 0; p--) begin
      present = p[0];
      bus(CMD_BUS_RESET, RSTL + RSTH);
      chk("mask_len", 8'h01, {7'h00, lo_n == RSTL + MASK2_CYC - MASK1_CYC});
      st_m[ST_PRES] = p[0];
      rd(1'b1);
    end
    cmd(CMD_WRITE_CFG, 8'ha5, 1'b1);
    chk("ext_armed", 8'h01, {7'h00, ext_pullup_ctrl_n});
    bus(CMD_SINGLE_BIT, SLOT_STD_CYC);
    chk("ext_on", 8'h00, {7'h00, ext_pullup_ctrl_n});
    bus(CMD_SINGLE_BIT, SLOT_STD_CYC);
    chk("ext_off", 8'h01, {7'h00, ext_pullup_ctrl_n});
    cmd(CMD_SET_PTR, PTR_CONFIG, 1'b1);
    rd(1'b1);
    cmd(CMD_WRITE_CFG, 8'ha5, 1'b1);
    bus(CMD_SINGLE_BIT, SLOT_STD_CYC);
    cmd(CMD_DEV_RESET, 8'h00, 1'b1);
    rd(1'b1);
    chk("ext_reset", 8'h01, {7'h00, ext_pullup_ctrl_n});
    cmd(CMD_SET_PTR, PTR_CONFIG, 1'b1);
    rd(1'b1);
    end_of_test();
  end
endmodule // swmwc_top_test
`default_nettype wire

// ### verilog/swmwc_slot.sv
`default_nettype none
module swmwc_slot
  import swmwc_pkg::*;
#(
  parameter int RSTL_STD = RSTL_STD_CYC,
  parameter int RSTH_STD = RSTH_STD_CYC,
  parameter int SLOT_STD = SLOT_STD_CYC,
  parameter int LOW0_STD = LOW0_STD_CYC,
  parameter int MSP_STD = MSP_STD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic abort,
  input wire swmwc_slot_req_s req,
  input wire logic line_in,
  output var swmwc_slot_rsp_s rsp
);
  localparam logic [16:0] M1 = 17'(MASK1_CYC);
  localparam logic [16:0] M2 = 17'(MASK2_CYC);
  localparam logic [16:0] APU_LAST = 17'(APUOT_CYC - 1);

  function automatic logic [16:0] pick(input logic od, input int s, input int o);
    return od ? 17'(o) : 17'(s);
  endfunction

  swmwc_slot_st_s st;
  swmwc_slot_st_s nx;
  logic [16:0] c;
  logic [16:0] lo_end;

  // ==========================================================
  // one slot: reset/presence or a single bit
  always_comb begin
    nx = st;
    nx.rsp.done = 1'b0;
    nx.rsp.rise = 1'b0;
    c = st.cnt + 17'h1;
    lo_end = '0;
    if (abort) begin
      nx = '0;
    end else if (!st.busy) begin
      if (req.start) begin
        nx.busy = 1'b1;
        nx.rst = req.rst_slot;
        nx.wbit = req.wbit;
        nx.hold = req.hold;
        nx.od = req.od;
        nx.active_pullup_en = req.active_pullup_en;
        nx.mask = req.mask;
        nx.cnt = '0;
        nx.apu_done = 1'b0;
        nx.apu_on = 1'b0;
        nx.rsp.pull_lo = 1'b1;
        nx.rsp.pull_hi = 1'b0;
        nx.rsp.short_det = 1'b0;
      end
    end else if (st.rst) begin
      nx.cnt = c;
      lo_end = pick(st.od, RSTL_STD, RSTL_OD_CYC);
      // no pullup assist here: presence and short recovery stay resistive
      nx.rsp.pull_lo = (c < lo_end) ||
        (st.mask && !st.od && c >= lo_end + M1 && c < lo_end + M2);
      if (c == lo_end + pick(st.od, SSI_STD_CYC, SSI_OD_CYC) && !line_in) begin
        nx.rsp.short_det = 1'b1;
      end
      if (c == lo_end + pick(st.od, MSP_STD, MSP_OD_CYC)) begin
        nx.rsp.pres = !line_in && !st.rsp.short_det;
      end
      if (c == lo_end + pick(st.od, RSTH_STD, RSTH_OD_CYC)) begin
        nx.busy = 1'b0;
        nx.rsp.done = 1'b1;
      end
    end else begin
      nx.cnt = c;
      lo_end = st.wbit ? pick(st.od, LOW1_STD_CYC, LOW1_OD_CYC) :
        pick(st.od, LOW0_STD, LOW0_OD_CYC);
      nx.rsp.pull_lo = c < lo_end;
      if (c == pick(st.od, MSR_STD_CYC, MSR_OD_CYC)) begin
        nx.rsp.sample = line_in;
      end
      // line past the threshold once released: assist it for a fixed time, or to the slot end when hold is set
      if (!st.rsp.pull_lo && (st.active_pullup_en || st.hold) && !st.apu_done && line_in) begin
        nx.apu_done = 1'b1;
        nx.apu_on = 1'b1;
        nx.apu_cnt = '0;
        nx.rsp.rise = 1'b1;
      end else if (st.apu_on) begin
        nx.apu_cnt = st.apu_cnt + 17'h1;
        if (st.apu_cnt == APU_LAST && !st.hold) begin
          nx.apu_on = 1'b0;
        end
      end
      if (c == pick(st.od, SLOT_STD, SLOT_OD_CYC)) begin
        nx.busy = 1'b0;
        nx.rsp.done = 1'b1;
        nx.apu_on = 1'b0;
      end
      nx.rsp.pull_hi = nx.apu_on;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign rsp = st.rsp;
endmodule // swmwc_slot
`default_nettype wire

// ### verilog/swmwc_top.sv
`default_nettype none
module swmwc_top
  import swmwc_pkg::*;
#(
  parameter int RSTL_STD = RSTL_STD_CYC,
  parameter int RSTH_STD = RSTH_STD_CYC,
  parameter int SLOT_STD = SLOT_STD_CYC,
  parameter int LOW0_STD = LOW0_STD_CYC,
  parameter int MSP_STD = MSP_STD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param,
  output logic cmd_ack,
  output logic cmd_nack,
  input wire logic rd_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic ext_pullup_ctrl_n,
  input wire logic addr_sel_lo,
  input wire logic addr_sel_hi,
  output logic [6:0] i2c_addr
);

  typedef struct packed {
    logic [3:0] cfg;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [7:0] rdata;
    swmwc_seq_e seq;
    logic [3:0] nbits;
    logic [7:0] shift;
    logic rd_byte;
    logic single;
    logic [1:0] tstep;
    logic tv;
    logic spu_on;
    swmwc_slot_req_s sreq;
    logic cmd_ack;
    logic cmd_nack;
    logic rd_valid;
    logic [7:0] rd_data;
    logic line_out;
    logic line_oe;
    logic ext_n;
    logic [6:0] i2c_addr;
  } swmwc_st_s;

  localparam swmwc_st_s ST_INIT = '{
    cfg: CFG_RESET,
    status: STATUS_RESET,
    ptr: PTR_STATUS,
    seq: SEQ_IDLE,
    ext_n: 1'b1,
    default: '0
  };

  // ==========================================================
  // helpers
  function automatic swmwc_slot_req_s mk_req(input logic r, input logic w,
                                             input logic h, input logic [3:0] cf);
    swmwc_slot_req_s q;
    q.start = 1'b1;
    q.rst_slot = r;
    q.wbit = w;
    q.hold = h;
    q.od = cf[CFG_ODS];
    q.active_pullup_en = cf[CFG_APU];
    q.mask = cf[CFG_PPM];
    return q;
  endfunction

  function automatic logic ptr_ok(input logic [7:0] p);
    return p == PTR_STATUS || p == PTR_RDATA || p == PTR_CONFIG;
  endfunction

  swmwc_st_s st;
  swmwc_st_s nx;
  swmwc_slot_rsp_s srsp;
  logic abort;
  logic armed;
  logic s;
  logic dir;
  logic [7:0] sh;

  // ==========================================================
  // waveform engine
  swmwc_slot #(
    .RSTL_STD(RSTL_STD),
    .RSTH_STD(RSTH_STD),
    .SLOT_STD(SLOT_STD),
    .LOW0_STD(LOW0_STD),
    .MSP_STD(MSP_STD)
  ) u_slot (
    .core_clk(core_clk),
    .reset(reset),
    .abort(abort),
    .req(st.sreq),
    .line_in(line_in),
    .rsp(srsp)
  );

  // ==========================================================
  // command decode, registers and sequencing
  always_comb begin
    nx = st;
    nx.cmd_ack = 1'b0;
    nx.cmd_nack = 1'b0;
    nx.rd_valid = 1'b0;
    nx.sreq.start = 1'b0;
    abort = cmd_valid && cmd_code == CMD_DEV_RESET;
    armed = st.cfg[CFG_SPU] && !st.spu_on;
    s = srsp.sample;
    sh = {srsp.sample, st.shift[7:1]};
    dir = 1'b0;
    nx.i2c_addr = {I2C_ADDR_BASE, addr_sel_hi, addr_sel_lo};

    // register reads
    if (rd_req) begin
      nx.rd_valid = 1'b1;
      case (st.ptr)
        PTR_STATUS: begin
          // level is only refreshed when status is actually read
          nx.status[ST_LEVEL] = line_in;
          nx.rd_data = {st.status[7:4], line_in, st.status[2:0]};
        end
        PTR_CONFIG: begin
          nx.rd_data = {4'h0, st.cfg};
        end
        PTR_RDATA: begin
          nx.rd_data = st.rdata;
        end
        default: begin
          nx.rd_data = 8'h00;
        end
      endcase
    end

    // slot completion
    if (srsp.rise && st.sreq.hold) begin
      nx.spu_on = 1'b1;
    end
    if (srsp.done) begin
      case (st.seq)
        SEQ_RESET: begin
          nx.status[ST_PRES] = srsp.pres;
          nx.status[ST_SHORT] = srsp.short_det;
          nx.status[ST_BUSY] = 1'b0;
          nx.seq = SEQ_IDLE;
        end
        SEQ_BITS: begin
          nx.shift = sh;
          nx.nbits = st.nbits - 4'h1;
          if (st.nbits == 4'h1) begin
            if (st.single) begin
              nx.status[ST_SBR] = s;
            end
            if (st.rd_byte) begin
              nx.rdata = sh;
            end
            nx.status[ST_BUSY] = 1'b0;
            nx.seq = SEQ_IDLE;
          end else begin
            // strong pullup may only ride on a single-bit command or the last bit of a byte write
            nx.sreq = mk_req(1'b0, sh[0],
                             armed && !st.rd_byte && st.nbits == 4'h2, st.cfg);
          end
        end
        SEQ_TRIP: begin
          nx.tstep = st.tstep + 2'h1;
          if (st.tstep == 2'h0) begin
            nx.status[ST_SBR] = s;
            nx.sreq = mk_req(1'b0, 1'b1, 1'b0, st.cfg);
          end else if (st.tstep == 2'h1) begin
            if (st.status[ST_SBR] != s) begin
              dir = st.status[ST_SBR];
            end else if (s) begin
              dir = 1'b1;
            end else begin
              dir = st.tv;
            end
            nx.status[ST_TSB] = s;
            nx.status[ST_DIR] = dir;
            nx.sreq = mk_req(1'b0, dir, 1'b0, st.cfg);
          end else begin
            nx.status[ST_BUSY] = 1'b0;
            nx.seq = SEQ_IDLE;
          end
        end
        default: begin
          nx.seq = SEQ_IDLE;
        end
      endcase
    end

    // host commands
    if (cmd_valid) begin
      case (cmd_code)
        CMD_DEV_RESET: begin
          nx.cfg = CFG_RESET;
          nx.status = STATUS_RESET;
          nx.ptr = PTR_STATUS;
          nx.seq = SEQ_IDLE;
          nx.spu_on = 1'b0;
          nx.sreq = '0;
          nx.cmd_ack = 1'b1;
        end
        CMD_SET_PTR: begin
          if (ptr_ok(cmd_param)) begin
            nx.ptr = cmd_param;
            nx.cmd_ack = 1'b1;
          end else begin
            nx.cmd_nack = 1'b1;
          end
        end
        CMD_WRITE_CFG: begin
          // a bad complement leaves every field, armed pullup included, alone
          if (st.status[ST_BUSY] || cmd_param[7:4] != ~cmd_param[3:0]) begin
            nx.cmd_nack = 1'b1;
          end else begin
            nx.cfg = cmd_param[3:0];
            nx.status[ST_RST] = 1'b0;
            nx.ptr = PTR_CONFIG;
            if (!cmd_param[CFG_SPU]) begin
              nx.spu_on = 1'b0;
            end
            nx.cmd_ack = 1'b1;
          end
        end
        CMD_BUS_RESET, CMD_SINGLE_BIT, CMD_WRITE_BYTE, CMD_READ_BYTE,
        CMD_TRIPLET: begin
          if (st.status[ST_BUSY]) begin
            nx.cmd_nack = 1'b1;
          end else begin
            nx.cmd_ack = 1'b1;
            nx.ptr = PTR_STATUS;
            nx.status[ST_BUSY] = 1'b1;
            nx.rd_byte = cmd_code == CMD_READ_BYTE;
            nx.single = cmd_code == CMD_SINGLE_BIT;
            nx.tstep = 2'h0;
            nx.tv = cmd_param[PARAM_BIT];
            if (st.spu_on) begin
              // any accepted bus command ends a running strong pullup
              nx.spu_on = 1'b0;
              nx.cfg[CFG_SPU] = 1'b0;
            end
            case (cmd_code)
              CMD_BUS_RESET: begin
                nx.seq = SEQ_RESET;
                nx.sreq = mk_req(1'b1, 1'b1, 1'b0, st.cfg);
              end
              CMD_SINGLE_BIT: begin
                nx.seq = SEQ_BITS;
                nx.nbits = 4'h1;
                nx.sreq = mk_req(1'b0, cmd_param[PARAM_BIT], armed, st.cfg);
              end
              CMD_WRITE_BYTE: begin
                nx.seq = SEQ_BITS;
                nx.nbits = 4'h8;
                nx.shift = cmd_param;
                nx.sreq = mk_req(1'b0, cmd_param[0], 1'b0, st.cfg);
              end
              CMD_READ_BYTE: begin
                nx.seq = SEQ_BITS;
                nx.nbits = 4'h8;
                nx.shift = 8'hff;
                nx.sreq = mk_req(1'b0, 1'b1, 1'b0, st.cfg);
              end
              default: begin
                nx.seq = SEQ_TRIP;
                nx.sreq = mk_req(1'b0, 1'b1, 1'b0, st.cfg);
              end
            endcase
          end
        end
        default: begin
          nx.cmd_nack = 1'b1;
        end
      endcase
    end

    // strong pullup over: hand the field back to the host as cleared
    if (st.spu_on && !nx.spu_on) begin
      nx.cfg[CFG_SPU] = 1'b0;
    end

    // pin drive: oe high whenever this end drives the line
    nx.line_oe = srsp.pull_lo || srsp.pull_hi || nx.spu_on;
    nx.line_out = !srsp.pull_lo && (srsp.pull_hi || nx.spu_on);
    if (abort) begin
      nx.line_oe = 1'b0;
      nx.line_out = 1'b0;
    end
    nx.ext_n = !nx.spu_on;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= ST_INIT;
    end else begin
      st <= nx;
    end
  end

  assign cmd_ack = st.cmd_ack;
  assign cmd_nack = st.cmd_nack;
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign line_out = st.line_out;
  assign line_oe = st.line_oe;
  assign ext_pullup_ctrl_n = st.ext_n;
  assign i2c_addr = st.i2c_addr;
endmodule // swmwc_top
`default_nettype wire
